//--- core/byte_fifo.sv
`default_nettype none
module byte_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction
  always_ff @(posedge core_clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
    if (!rst_b_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= bump(wr_ptr);
      if (pop)
        rd_ptr <= bump(rd_ptr);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

//--- core/mode_initiator.sv
`default_nettype none
module mode_initiator
  import tape_vendor_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  mode_link_if.initiator link,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire tape_vendor_pkg::op_t cmd_op_i,
  input wire logic [7:0] cmd_page_i,
  input wire logic [39:0] cmd_bytes_i,
  output logic [39:0] sense_bytes_o,
  output logic done_o
);
  import tape_vendor_pkg::*;
  logic busy;
  op_t op;
  logic [39:0] out_bytes;
  logic [2:0] sent;
  logic [2:0] got;
  logic [7:0] page;
  assign cmd_ready_o = !busy;
  assign link.req_valid = busy && (sent == 3'h7);
  assign link.req_op = op;
  assign link.page_code = page;
  assign link.wr_data = out_bytes[7:0];
  // No bytes once a skipped request has already finished
  assign link.wr_valid = busy && (op == OP_SELECT) && (sent < 3'h5) &&
    !link.op_done;
  assign link.rd_ready = busy && (op == OP_SENSE);
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      busy <= 1'b0;
      op <= OP_IDLE;
      out_bytes <= '0;
      sent <= 3'h0;
      got <= 3'h0;
      page <= 8'h00;
      sense_bytes_o <= '0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (cmd_valid_i && !busy)
      begin
        busy <= 1'b1;
        op <= cmd_op_i;
        page <= cmd_page_i;
        out_bytes <= cmd_bytes_i;
        sent <= 3'h7;
        got <= 3'h0;
      end
      else if (busy)
      begin
        if (link.req_valid && link.req_ready)
          sent <= 3'h0;
        if (link.wr_valid && link.wr_ready)
        begin
          out_bytes <= {8'h00, out_bytes[39:8]};
          sent <= sent + 3'h1;
        end
        if (link.rd_valid && link.rd_ready)
        begin
          sense_bytes_o <= {link.rd_data, sense_bytes_o[39:8]};
          got <= got + 3'h1;
        end
        if (link.op_done)
        begin
          busy <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- core/mode_link_if.sv
`default_nettype none
interface mode_link_if;
  import tape_vendor_pkg::*;
  logic req_valid;
  logic req_ready;
  op_t req_op;
  logic [7:0] page_code;
  logic [7:0] wr_data;
  logic wr_valid;
  logic wr_ready;
  logic [7:0] rd_data;
  logic rd_valid;
  logic rd_ready;
  logic op_done;
  modport device (input req_valid, req_op, page_code, wr_data, wr_valid,
    rd_ready, output req_ready, wr_ready, rd_data, rd_valid, op_done);
  modport initiator (output req_valid, req_op, page_code, wr_data,
    wr_valid, rd_ready, input req_ready, wr_ready, rd_data, rd_valid,
    op_done);
endinterface
`default_nettype wire

//--- core/tape_vendor_mode_params.sv
`default_nettype none
// Summary of operation
// - Bytes apply only when page code zero
// - Cartridge kind: zero domestic, one international
// - Stay-connected flag forbids data-phase disconnect
// - Free mode block limit 240 KBytes
// - Stay mode transfer and block 160 KBytes
// - Stay write waits for enough free space
// - Stay read waits for transfer buffered, capped at 160 KBytes
// - Stay mode forces bad reselect level A0h
// - Legacy busy reads one, writes ignored
// - Aligned disconnect on two or four bytes
// - Parity checked when flag set, default one
// - Autoload threads tape unless inhibited
// - European flag overrides cartridge kind
// - Motion level 4K units, default 80h
// - Write starts tape at motion level
// - Read refills tape at motion level
// - Reselect level 4K units, default 80h
// - Write reselects when free reaches level
// - Read reselects when content reaches level
// - Empty write buffer: limited gaps then decide
// - Gap limit 00h to 07h, default 07h
// - Before stop fill track and one gap track
module tape_vendor_mode_params
  import tape_vendor_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 8,
  parameter bit FOUR_BYTE_ALIGN = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  mode_link_if.device link,
  input wire logic write_active_i,
  input wire logic read_active_i,
  input wire logic [tape_vendor_pkg::BUF_UNITS_W-1:0] buf_fill_i,
  input wire logic [23:0] xfer_len_i,
  input wire logic [23:0] block_len_i,
  input wire logic [23:0] buf_free_bytes_i,
  input wire logic [23:0] buf_held_bytes_i,
  input wire logic [23:0] byte_count_i,
  input wire logic parity_ok_i,
  input wire logic byte_strobe_i,
  input wire logic cart_inserted_i,
  input wire logic track_end_i,
  input wire logic gap_block_done_i,
  input wire logic gap_track_done_i,
  output logic cartridge_kind_o,
  output logic european_cartridge_o,
  output logic stay_connected_o,
  output logic aligned_disconnect_o,
  output logic bus_parity_check_o,
  output logic autoload_inhibit_o,
  output logic [7:0] motion_level_o,
  output logic [7:0] reselect_level_o,
  output logic [7:0] gap_limit_o,
  output logic length_ok_o,
  output logic data_phase_go_o,
  output logic disconnect_ok_o,
  output logic parity_error_o,
  output logic thread_tape_o,
  output logic tape_motion_o,
  output logic reselect_o,
  output logic write_gap_o,
  output logic tape_stopped_o
);
  import tape_vendor_pkg::*;
  typedef enum logic [2:0] {W_IDLE, W_DATA, W_GAPS, W_FILL, W_TRACKS}
    wr_state_t;
  logic [7:0] flags;
  logic [7:0] euro;
  logic [7:0] motion;
  logic [7:0] reselect;
  logic [7:0] gap_limit;
  logic [2:0] index;
  logic active;
  op_t op;
  logic [7:0] gap_count;
  logic [1:0] track_count;
  logic cart_seen;
  logic [7:0] rd_byte;
  wr_state_t wr_state;
  wire logic [7:0] q_data;
  wire logic q_valid;
  wire logic q_ready;

  function automatic logic [7:0] clamp_level(input logic [7:0] v);
    clamp_level = (v < LEVEL_MIN) ? LEVEL_MIN :
      (v > LEVEL_MAX) ? LEVEL_MAX : v;
  endfunction

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(link.wr_valid),
    .in_ready_o(link.wr_ready),
    .in_data_i(link.wr_data),
    .out_valid_o(q_valid),
    .out_ready_i(q_ready),
    .out_data_o(q_data)
  );

  wire logic last_index = (index == OFS_GAP);
  wire logic start_op = link.req_valid && !active;
  assign link.req_ready = !active;
  wire logic non_page = (link.page_code == PAGE_NON_PAGE);
  wire logic sel_step = active && (op == OP_SELECT) && q_valid;
  assign q_ready = active && (op == OP_SELECT);
  wire logic sense_step = active && (op == OP_SENSE) && link.rd_ready;
  assign link.rd_valid = active && (op == OP_SENSE);
  // Sense byte is preloaded for the index served next
  wire logic [2:0] rd_index = start_op ? OFS_XFER_FLAGS : index + 3'h1;
  wire logic stay = flags[BIT_STAY_CONN];
  wire logic [7:0] lvl_stay = ((reselect < STAY_LEVEL_MIN) ||
    (reselect > STAY_LEVEL_MAX)) ? STAY_LEVEL_MIN : reselect;
  wire logic [7:0] eff_reselect = stay ? lvl_stay : reselect;
  wire logic [BUF_UNITS_W-1:0] free_units = BUF_CAPACITY - buf_fill_i;

  always_comb
  begin
    rd_byte = 8'h00;
    unique case (rd_index)
      OFS_XFER_FLAGS: rd_byte = (flags & FLAGS_WRITE_MASK) |
        (8'h01 << BIT_LEGACY_BUSY);
      OFS_EURO: rd_byte = euro & EURO_WRITE_MASK;
      OFS_MOTION: rd_byte = motion;
      OFS_RESELECT: rd_byte = eff_reselect;
      OFS_GAP: rd_byte = gap_limit;
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      flags <= FLAGS_RESET;
      euro <= EURO_RESET;
      motion <= LEVEL_RESET;
      reselect <= LEVEL_RESET;
      gap_limit <= GAP_RESET;
      active <= 1'b0;
      op <= OP_IDLE;
      index <= '0;
      link.op_done <= 1'b0;
      link.rd_data <= 8'h00;
    end
    else
    begin
      link.op_done <= 1'b0;
      if (start_op)
      begin
        active <= non_page && (link.req_op != OP_IDLE);
        link.op_done <= !non_page || (link.req_op == OP_IDLE);
        op <= link.req_op;
        index <= OFS_XFER_FLAGS;
        link.rd_data <= rd_byte;
      end
      else if (sel_step || sense_step)
      begin
        if (sel_step)
        begin
          unique case (index)
            OFS_XFER_FLAGS: flags <= q_data & FLAGS_WRITE_MASK;
            OFS_EURO: euro <= q_data & EURO_WRITE_MASK;
            OFS_MOTION: motion <= clamp_level(q_data);
            OFS_RESELECT: reselect <= clamp_level(q_data);
            OFS_GAP: gap_limit <= (q_data > GAP_MAX) ? GAP_MAX : q_data;
            default: ;
          endcase
        end
        index <= index + 3'h1;
        if (last_index)
        begin
          active <= 1'b0;
          link.op_done <= 1'b1;
        end
      end
      if (sense_step)
        link.rd_data <= rd_byte;
    end
  end

  assign cartridge_kind_o = flags[BIT_CART_KIND] | euro[BIT_EURO];
  assign european_cartridge_o = euro[BIT_EURO];
  assign stay_connected_o = stay;
  assign aligned_disconnect_o = flags[BIT_ALIGNED_DISC];
  assign bus_parity_check_o = flags[BIT_PARITY];
  assign autoload_inhibit_o = flags[BIT_AUTOLOAD_INH];
  assign motion_level_o = motion;
  assign reselect_level_o = eff_reselect;
  assign gap_limit_o = gap_limit;
  assign length_ok_o = stay ?
    ((xfer_len_i <= MAX_XFER_STAY) && (block_len_i <= MAX_XFER_STAY)) :
    (block_len_i <= MAX_BLOCK_FREE);
  wire logic [23:0] want_rd = (xfer_len_i > MAX_XFER_STAY) ?
    MAX_XFER_STAY : xfer_len_i;
  assign data_phase_go_o = !stay ||
    (write_active_i && (buf_free_bytes_i >= xfer_len_i)) ||
    (read_active_i && (buf_held_bytes_i >= want_rd));
  wire logic align_hit = FOUR_BYTE_ALIGN ? (byte_count_i[1:0] == 2'b00) :
    !byte_count_i[0];
  assign disconnect_ok_o = !stay &&
    (!flags[BIT_ALIGNED_DISC] || align_hit);
  assign thread_tape_o = cart_seen && !flags[BIT_AUTOLOAD_INH];
  assign tape_motion_o = (wr_state != W_IDLE) ||
    (read_active_i && (buf_fill_i <= {1'b0, motion}));
  assign reselect_o = (write_active_i &&
    (free_units >= {1'b0, eff_reselect})) ||
    (read_active_i && (buf_fill_i >= {1'b0, eff_reselect}));
  assign write_gap_o = (wr_state == W_GAPS) || (wr_state == W_FILL) ||
    (wr_state == W_TRACKS);

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      parity_error_o <= 1'b0;
      cart_seen <= 1'b0;
      wr_state <= W_IDLE;
      gap_count <= 8'h00;
      track_count <= 2'h0;
      tape_stopped_o <= 1'b1;
    end
    else
    begin
      parity_error_o <= bus_parity_check_o && byte_strobe_i &&
        !parity_ok_i;
      cart_seen <= cart_inserted_i;
      tape_stopped_o <= (wr_state == W_IDLE);
      unique case (wr_state)
        W_IDLE:
          if (write_active_i && (buf_fill_i >= {1'b0, motion}))
            wr_state <= W_DATA;
        W_DATA:
          if (buf_fill_i == '0)
          begin
            wr_state <= W_GAPS;
            gap_count <= 8'h00;
          end
        W_GAPS:
          if (buf_fill_i != '0 && gap_count >= gap_limit)
            wr_state <= W_DATA;
          else if (gap_count >= gap_limit)
            wr_state <= W_FILL;
          else if (gap_block_done_i)
            gap_count <= gap_count + 8'h01;
        W_FILL:
          if (track_end_i)
          begin
            wr_state <= W_TRACKS;
            track_count <= 2'h0;
          end
        W_TRACKS:
          if (gap_track_done_i)
          begin
            if (track_count + 2'h1 >= GAP_TRACKS_DEFAULT)
              wr_state <= W_IDLE;
            else
              track_count <= track_count + 2'h1;
          end
        default: wr_state <= W_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- core/tape_vendor_pkg.sv
`default_nettype none
package tape_vendor_pkg;
  localparam int unsigned PARAM_BYTES = 5;
  localparam logic [2:0] OFS_XFER_FLAGS = 3'h0;
  localparam logic [2:0] OFS_EURO = 3'h1;
  localparam logic [2:0] OFS_MOTION = 3'h2;
  localparam logic [2:0] OFS_RESELECT = 3'h3;
  localparam logic [2:0] OFS_GAP = 3'h4;
  localparam int unsigned BIT_CART_KIND = 7;
  localparam int unsigned BIT_STAY_CONN = 5;
  localparam int unsigned BIT_LEGACY_BUSY = 3;
  localparam int unsigned BIT_ALIGNED_DISC = 2;
  localparam int unsigned BIT_PARITY = 1;
  localparam int unsigned BIT_AUTOLOAD_INH = 0;
  localparam int unsigned BIT_EURO = 0;
  localparam logic [7:0] FLAGS_WRITE_MASK = 8'ha7;
  localparam logic [7:0] EURO_WRITE_MASK = 8'h01;
  localparam logic [7:0] FLAGS_RESET = 8'h02;
  localparam logic [7:0] EURO_RESET = 8'h00;
  localparam logic [7:0] LEVEL_RESET = 8'h80;
  localparam logic [7:0] LEVEL_MIN = 8'h20;
  localparam logic [7:0] LEVEL_MAX = 8'hd0;
  localparam logic [7:0] STAY_LEVEL_MIN = 8'ha0;
  localparam logic [7:0] STAY_LEVEL_MAX = 8'hc0;
  localparam logic [7:0] GAP_RESET = 8'h07;
  localparam logic [7:0] GAP_MAX = 8'h07;
  localparam logic [7:0] PAGE_NON_PAGE = 8'h00;
  // Byte limits
  localparam logic [23:0] MAX_BLOCK_FREE = 24'h03c000;
  localparam logic [23:0] MAX_XFER_STAY = 24'h028000;
  // Buffer amounts in 4 KByte units, 4 KByte is 2^12
  localparam int unsigned UNIT_SHIFT = 12;
  localparam int unsigned BUF_UNITS_W = 9;
  localparam logic [8:0] BUF_CAPACITY = 9'h100;
  localparam logic [1:0] GAP_TRACKS_DEFAULT = 2'h1;
  typedef enum logic [1:0] {OP_IDLE, OP_SELECT, OP_SENSE} op_t;
endpackage
`default_nettype wire

//--- sim/tape_link_props.sv
`default_nettype none
module tape_link_props
  import tape_vendor_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire tape_vendor_pkg::op_t req_op,
  input wire logic [7:0] page_code,
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic op_done
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [3:0] wr_cnt;
  logic sel_page0;
  wire take = req_valid && req_ready;
  wire wr_hs = wr_valid && wr_ready;
  wire applies = take && page_code == PAGE_NON_PAGE;
  // Bytes accepted since the last request
  always_ff @(posedge core_clk_i)
  begin
    wr_cnt <= (!rst_b_i || take) ? 4'(wr_hs) : wr_cnt + 4'(wr_hs);
    sel_page0 <= !rst_b_i ? 1'b0 :
      take ? applies && req_op == OP_SELECT : sel_page0;
  end
  property p_skip;
    take && page_code != PAGE_NON_PAGE |=> op_done;
  endproperty
  a_skip: assert property (p_skip)
    else $error("skipped page did not finish at once");
  property p_idle;
    take && req_op == OP_IDLE |=> op_done;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle request did not finish at once");
  property p_pulse;
    op_done |=> !op_done;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("done longer than one cycle");
  property p_sel_done;
    applies && req_op == OP_SELECT |-> ##[1:200] op_done;
  endproperty
  a_sel_done: assert property (p_sel_done)
    else $error("select never finished");
  property p_sense_done;
    applies && req_op == OP_SENSE |-> ##[1:200] op_done;
  endproperty
  a_sense_done: assert property (p_sense_done)
    else $error("sense never finished");
  property p_five;
    op_done && sel_page0 |-> wr_cnt == 4'h5;
  endproperty
  a_five: assert property (p_five)
    else $error("select did not move five bytes");
  property p_wr_hold;
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_data);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("select byte dropped before taken");
  property p_req_hold;
    req_valid && !req_ready |=> req_valid && $stable(page_code);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request changed before taken");
  property p_rd_hold;
    rd_valid && !rd_ready |=> rd_valid;
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("sense byte withdrawn");
  c_sel: cover property (applies && req_op == OP_SELECT);
  c_sense: cover property (applies && req_op == OP_SENSE);
  c_skip: cover property (take && page_code != PAGE_NON_PAGE);
endmodule
`default_nettype wire

//--- sim/test_tape_vendor_mode_params.sv
`default_nettype none
module test_tape_vendor_mode_params;
  timeunit 1ns;
  timeprecision 1ns;
  import tape_vendor_pkg::*;
  typedef struct packed {logic sense; logic [39:0] v;} note_t;
  logic core_clk = 0, rst_b = 0, pend = 0;
  logic cmd_valid, cmd_ready, done, wr_act, par_ok, strobe, cart;
  logic cart_o, euro_o, stay_o, align_o, par_o, inh_o, len_ok, perr;
  logic thread, motion, disc;
  op_t cmd_op;
  logic [7:0] cmd_page, mot_o, res_o, gap_o;
  logic [7:0] mf = 8'h02, me = 8'h00, mm = 8'h80, mr = 8'h80, mg = 8'h07;
  logic [8:0] fill;
  logic [23:0] xlen, blen, bcnt;
  logic [39:0] cmd_bytes, sense;
  int checked = 0, failures = 0;
  note_t notes[$];
  note_t nt;
  mode_link_if link();
  tape_vendor_mode_params u_tape_vendor_mode_params (
    .core_clk_i(core_clk), .rst_b_i(rst_b),
    .link(link), .write_active_i(wr_act), .read_active_i(strobe),
    .buf_fill_i(fill), .xfer_len_i(xlen), .block_len_i(blen),
    .buf_free_bytes_i(xlen), .buf_held_bytes_i(24'h0),
    .byte_count_i(bcnt), .parity_ok_i(par_ok), .byte_strobe_i(strobe),
    .cart_inserted_i(cart), .track_end_i(1'b0), .gap_block_done_i(1'b0),
    .gap_track_done_i(1'b0), .cartridge_kind_o(cart_o),
    .european_cartridge_o(euro_o), .stay_connected_o(stay_o),
    .aligned_disconnect_o(align_o), .bus_parity_check_o(par_o),
    .autoload_inhibit_o(inh_o), .motion_level_o(mot_o),
    .reselect_level_o(res_o), .gap_limit_o(gap_o), .length_ok_o(len_ok),
    .data_phase_go_o(), .disconnect_ok_o(disc), .parity_error_o(perr),
    .thread_tape_o(thread), .tape_motion_o(motion), .reselect_o(),
    .write_gap_o(), .tape_stopped_o());
  mode_initiator u_mode_initiator (.core_clk_i(core_clk), .rst_b_i(rst_b),
    .link(link), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_op_i(cmd_op), .cmd_page_i(cmd_page), .cmd_bytes_i(cmd_bytes),
    .sense_bytes_o(sense), .done_o(done));
  tape_link_props u_tape_link_props (.core_clk_i(core_clk), .rst_b_i(rst_b),
    .req_valid(link.req_valid), .req_ready(link.req_ready),
    .req_op(link.req_op), .page_code(link.page_code),
    .wr_data(link.wr_data), .wr_valid(link.wr_valid),
    .wr_ready(link.wr_ready), .rd_data(link.rd_data),
    .rd_valid(link.rd_valid), .rd_ready(link.rd_ready),
    .op_done(link.op_done));
  always #20 core_clk = ~core_clk;
  task automatic cmp_vec(input logic [39:0] got, input logic [39:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    cmp_vec({39'h0, got}, {39'h0, exp});
  endtask
  function automatic logic [39:0] cfg_now();
    return {10'h0, cart_o, euro_o, stay_o, align_o, par_o, inh_o, mot_o,
      res_o, gap_o};
  endfunction
  function automatic logic [39:0] exp_cfg();
    // European flag overrides the cartridge kind
    return {10'h0, mf[7] | me[0], me[0], mf[5], mf[2], mf[1], mf[0], mm,
      mr, mg};
  endfunction
  function automatic logic [7:0] clampl(input logic [7:0] x);
    return x < LEVEL_MIN ? LEVEL_MIN : (x > LEVEL_MAX ? LEVEL_MAX : x);
  endfunction
  task automatic cmd(input op_t op, input logic [7:0] pg,
    input logic [39:0] b);
    int n;
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_page <= pg;
    cmd_bytes <= b;
    for (n = 0; n < 200; n++)
    begin
      @(posedge core_clk);
      if (cmd_ready === 1'b1)
        break;
    end
    if (n == 200)
      failures++;
    cmd_valid <= 1'b0;
    for (n = 0; n < 300 && done !== 1'b1; n++)
      @(posedge core_clk);
    if (n == 300)
      failures++;
  endtask
  task automatic sel(input logic [7:0] pg, input logic [39:0] b);
    if (pg == PAGE_NON_PAGE)
    begin
      mf = b[7:0] & FLAGS_WRITE_MASK;
      me = b[15:8] & EURO_WRITE_MASK;
      mm = clampl(b[23:16]);
      mr = clampl(b[31:24]);
      if (mf[5] && (mr < STAY_LEVEL_MIN || mr > STAY_LEVEL_MAX))
        mr = STAY_LEVEL_MIN;
      mg = b[39:32] > GAP_MAX ? GAP_MAX : b[39:32];
    end
    notes.push_back({1'b0, exp_cfg()});
    cmd(OP_SELECT, pg, b);
    notes.push_back({1'b1, mg, mr, mm, me, mf | 8'h08});
    cmd(OP_SENSE, PAGE_NON_PAGE, 40'h0);
  endtask
  // Result watcher, one cycle after each completion
  always @(posedge core_clk)
  begin
    if (pend && notes.size() > 0)
    begin
      nt = notes.pop_front();
      cmp_vec(nt.sense ? sense : cfg_now(), nt.v);
    end
    pend <= (done === 1'b1);
  end
  task automatic finish_test;
    if (notes.size() != 0)
      failures++;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #(40 * 20000);
    failures++;
    finish_test();
  end
  initial
  begin
    void'($urandom(87));
    {cmd_valid, wr_act, strobe, cart, par_ok} = 5'h1;
    cmd_op = OP_IDLE;
    {cmd_page, cmd_bytes, fill, xlen, blen, bcnt} = '0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    @(negedge core_clk);
    cmp_vec(cfg_now(), exp_cfg());
    @(posedge core_clk);
    cart <= 1'b1;
    wr_act <= 1'b1;
    fill <= 9'h07f;
    blen <= MAX_BLOCK_FREE + 24'h1;
    xlen <= 24'h000400;
    bcnt <= 24'({$urandom, 1'b1});
    strobe <= 1'b1;
    par_ok <= 1'b0;
    @(posedge core_clk);
    strobe <= 1'b0;
    par_ok <= 1'b1;
    @(negedge core_clk);
    cmp_flag(thread, 1'b1);
    cmp_flag(motion, 1'b0);
    cmp_flag(len_ok, 1'b0);
    cmp_flag(perr, 1'b1);
    cmp_flag(disc, 1'b1);
    @(posedge core_clk);
    fill <= 9'h080;
    blen <= MAX_BLOCK_FREE;
    // Start of motion is registered, one more edge
    @(posedge core_clk);
    @(negedge core_clk);
    cmp_flag(motion, 1'b1);
    cmp_flag(len_ok, 1'b1);
    $display("test defaults done");
    sel(PAGE_NON_PAGE, 40'hff_e0_10_ff_ff);
    @(posedge core_clk);
    xlen <= MAX_XFER_STAY;
    blen <= 24'h000400;
    @(negedge core_clk);
    cmp_flag(len_ok, 1'b1);
    cmp_flag(thread, 1'b0);
    cmp_flag(disc, 1'b0);
    @(posedge core_clk);
    xlen <= MAX_XFER_STAY + 24'h1;
    @(negedge core_clk);
    cmp_flag(len_ok, 1'b0);
    $display("test stay mode done");
    sel(PAGE_NON_PAGE, 40'h07_80_80_00_04);
    @(posedge core_clk);
    bcnt <= 24'({$urandom, 1'b1});
    @(negedge core_clk);
    cmp_flag(disc, 1'b0);
    @(posedge core_clk);
    bcnt <= 24'({$urandom, 1'b0});
    @(negedge core_clk);
    cmp_flag(disc, 1'b1);
    $display("test aligned disconnect done");
    sel(8'($urandom_range(255, 1)), 40'({$urandom, $urandom}));
    notes.push_back({1'b0, exp_cfg()});
    cmd(OP_IDLE, PAGE_NON_PAGE, 40'h0);
    $display("test other page done");
    repeat (6)
      sel(PAGE_NON_PAGE, 40'({$urandom, $urandom}));
    $display("test random select done");
    repeat (3) @(posedge core_clk);
    finish_test();
  end
endmodule
`default_nettype wire
